// ### hw/cfa_pkg.sv
// Purpose: shared constants for the charger fault and alarm event registers
// Assumes: eight-bit registers reached through a simple register port
// Notes:   offsets are byte register addresses on the serial control port
package cfa_pkg;

  localparam int          DATA_W            = 8;
  localparam logic [7:0]  ADDR_ALARM_MASK   = 8'h0F;
  localparam logic [7:0]  ADDR_FAULT_LIVE   = 8'h10;
  localparam logic [7:0]  ADDR_FAULT_LATCH  = 8'h11;
  localparam logic [7:0]  ADDR_FAULT_MASK   = 8'h12;
  localparam logic [7:0]  ADDR_ALARM_LATCH  = 8'h0E;
  localparam logic [7:0]  MASK_RESET        = 8'h00;
  localparam logic [7:0]  FLAG_RESET        = 8'h00;

  // alarm bit positions
  localparam int BIT_BAT_OV_ALM   = 7;
  localparam int BIT_BAT_OC_ALM   = 6;
  localparam int BIT_IN_OV_ALM    = 5;
  localparam int BIT_IN_OC_ALM    = 4;
  localparam int BIT_BAT_UC_ALM   = 3;
  localparam int BIT_ADAPTER      = 2;
  localparam int BIT_BAT_ATTACH   = 1;
  localparam int BIT_CONV_DONE    = 0;

  // fault bit positions
  localparam int BIT_BAT_OV       = 7;
  localparam int BIT_BAT_OC       = 6;
  localparam int BIT_IN_OV        = 5;
  localparam int BIT_IN_OC        = 4;
  localparam int BIT_NEAR_LIMIT   = 3;
  localparam int BIT_BAT_OT       = 2;
  localparam int BIT_CONN_OT      = 1;
  localparam int BIT_DIE_OT       = 0;

  // near-limit window is 5 percent of the fault level
  localparam int NEAR_PCT         = 5;
  localparam int PCT_FULL         = 100;

endpackage

// ### hw/cfa_evt_if.sv
// Purpose: carrier between the register block and the sticky flag bank
// Assumes: single clock domain
// Notes:   one bundle per group of eight events
`timescale 1ns/1ps
interface cfa_evt_if #(parameter int W = 8);
  logic [W-1:0] cond;
  logic [W-1:0] flags;
  logic         rd_clear;
  logic         soft_rst;
  modport bank (input cond, input rd_clear, input soft_rst, output flags);
  modport ctrl (output cond, output rd_clear, output soft_rst, input flags);
endinterface

// ### hw/cfa_flag_bank.sv
// Purpose: sticky event flags, cleared by a read, set winning over clear
// Assumes: cond is synchronous to core_clk
// Notes:   a condition present during the clearing read stays latched
`timescale 1ns/1ps
module cfa_flag_bank #(
  parameter int W = 8
) (
  // clock and reset
  input  wire logic core_clk,
  input  wire logic reset_n,
  // event bundle
  cfa_evt_if.bank   evt
);

  logic [W-1:0] flags_reg;
  logic [W-1:0] flags_next;

  // R10: clear on read
  // R11: sticky latch
  always_comb begin
    flags_next = evt.rd_clear ? evt.cond : (flags_reg | evt.cond);
    if (evt.soft_rst) begin
      flags_next = W'(cfa_pkg::FLAG_RESET);
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      flags_reg <= W'(cfa_pkg::FLAG_RESET);
    end else begin
      flags_reg <= flags_next;
    end
  end

  assign evt.flags = flags_reg;

  // R10: no drop without read
  AST_FLAG_HOLDS: assert property (@(posedge core_clk) disable iff (!reset_n) // R10
    (!evt.rd_clear && !evt.soft_rst) |=> ((flags_reg & $past(flags_reg)) == $past(flags_reg)))
    else $error("sticky flag dropped without a read");

  // R11: present condition latched
  AST_FLAG_SETS: assert property (@(posedge core_clk) disable iff (!reset_n) // R11
    (!evt.soft_rst) |=> ((flags_reg & $past(evt.cond)) == $past(evt.cond)))
    else $error("present condition not latched");

  // R10: read clears flags
  AST_FLAG_CLEARS: assert property (@(posedge core_clk) disable iff (!reset_n) // R10
    (evt.rd_clear && !evt.soft_rst) |=> (flags_reg == $past(evt.cond)))
    else $error("read did not clear the sticky flags");

  // R10: soft reset clears
  AST_FLAG_SOFT_CLEAR: assert property (@(posedge core_clk) disable iff (!reset_n) // R10
    evt.soft_rst |=> (flags_reg == W'(cfa_pkg::FLAG_RESET)))
    else $error("soft reset left sticky flags set");

endmodule // cfa_flag_bank

// ### hw/cfa_fault_alarm_regs.sv
// Purpose: alarm and fault event registers with masked active-low interrupt
// Assumes: register port strobes are one-cycle pulses synchronous to core_clk
// Notes:   temperature readings are compared as unsigned codes; lower sense code is hotter, higher die code is hotter
`timescale 1ns/1ps

// Operation
// R1: alarm mask bit 1 keeps that event off the interrupt; 0 passes it.
// R2: eight alarm mask bits are read-write, reset to 0, cleared by soft reset.
// R3: alarm bits: 7 bat OV, 6 bat OC, 5 in OV, 4 in OC, 3 UC, 2,1,0.
// R4: live fault bits are read-only and follow the present condition.
// R5: fault bits: 7 bat OV, 6 bat OC, 5 in OV, 4 in OC, 3..0 thermal.
// R6: near-limit status set while either sensor is within 5% of its fault level.
// R7: battery over-temperature set when battery sense is below its fault level.
// R8: connector over-temperature set when connector sense is below its fault level.
// R9: die alarm set when die temperature exceeds the die alarm level.
// R10: fault flags are sticky and cleared only by reading the flag register; soft reset also clears them here.
// R11: a fault flag stays 1 if the fault occurred since the last read.
// R12: near-limit flag latches if either sensor came within 5% since clearing.
// R13: alarm flags at alarm mask positions latch on crossings, clear on read.
// R14: fault mask bits, reset 0, keep set faults off the interrupt.
// R15: interrupt low while any unmasked flag is pending, released otherwise.
module cfa_fault_alarm_regs #(
  parameter int TW = 12
) (
  // clock and reset
  input  wire logic          core_clk,
  input  wire logic          reset_n,
  // register port
  input  wire logic [7:0]    reg_addr,
  input  wire logic          reg_wr,
  input  wire logic          reg_rd,
  input  wire logic [7:0]    reg_wdata,
  output logic      [7:0]    reg_rdata,
  input  wire logic          soft_reset,
  // alarm sources
  input  wire logic [7:0]    alarm_cond,
  // fault sources
  input  wire logic          battery_overvoltage,
  input  wire logic          battery_overcurrent,
  input  wire logic          input_overvoltage,
  input  wire logic          input_overcurrent,
  // temperature readings and levels
  input  wire logic [TW-1:0] battery_temp_sense,
  input  wire logic [TW-1:0] battery_temp_fault_level,
  input  wire logic [TW-1:0] connector_temp_sense,
  input  wire logic [TW-1:0] connector_temp_fault_level,
  input  wire logic [TW-1:0] die_temp,
  input  wire logic [TW-1:0] die_temp_alarm_level,
  // interrupt
  output logic               int_n
);

  logic [7:0] alarm_mask_reg;
  logic [7:0] fault_mask_reg;
  logic [7:0] fault_live_reg;
  logic [7:0] fault_live_next;
  logic [7:0] rdata_next;
  logic       near_bat;
  logic       near_conn;

  cfa_evt_if #(.W(8)) alarm_evt ();
  cfa_evt_if #(.W(8)) fault_evt ();

  // ------------------------------------------------------------------
  // near-limit window
  // ------------------------------------------------------------------
  // true when sense lies within pct percent of level, either side
  function automatic logic within_pct(input logic [TW-1:0] sense,
                                      input logic [TW-1:0] level);
    logic [TW+7:0] diff;
    logic [TW+7:0] lhs;
    logic [TW+7:0] rhs;
    diff = (sense >= level) ? (TW+8)'(sense - level) : (TW+8)'(level - sense);
    lhs  = (TW+8)'(diff * cfa_pkg::PCT_FULL);
    rhs  = (TW+8)'(level * cfa_pkg::NEAR_PCT);
    return lhs <= rhs;
  endfunction

  assign near_bat  = within_pct(battery_temp_sense, battery_temp_fault_level);
  assign near_conn = within_pct(connector_temp_sense, connector_temp_fault_level);

  // ------------------------------------------------------------------
  // live fault state
  // ------------------------------------------------------------------
  // R4: follows present condition
  // R5: bit placement
  always_comb begin
    fault_live_next                          = 8'h00;
    fault_live_next[cfa_pkg::BIT_BAT_OV]     = battery_overvoltage;
    fault_live_next[cfa_pkg::BIT_BAT_OC]     = battery_overcurrent;
    fault_live_next[cfa_pkg::BIT_IN_OV]      = input_overvoltage;
    fault_live_next[cfa_pkg::BIT_IN_OC]      = input_overcurrent;
    // R6: near-limit window
    fault_live_next[cfa_pkg::BIT_NEAR_LIMIT] = near_bat | near_conn;
    // R7: battery sense low
    fault_live_next[cfa_pkg::BIT_BAT_OT]     = battery_temp_sense < battery_temp_fault_level;
    // R8: connector sense low
    fault_live_next[cfa_pkg::BIT_CONN_OT]    = connector_temp_sense < connector_temp_fault_level;
    // R9: die above alarm
    fault_live_next[cfa_pkg::BIT_DIE_OT]     = die_temp > die_temp_alarm_level;
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      fault_live_reg <= cfa_pkg::FLAG_RESET;
    end else begin
      fault_live_reg <= fault_live_next;
    end
  end

  // ------------------------------------------------------------------
  // sticky flags
  // ------------------------------------------------------------------
  // R12: near-limit latches via bank
  assign fault_evt.cond     = fault_live_reg;
  assign fault_evt.rd_clear = reg_rd && (reg_addr == cfa_pkg::ADDR_FAULT_LATCH);
  assign fault_evt.soft_rst = soft_reset;
  // R13: alarm event flags
  // R3: alarm bit order
  assign alarm_evt.cond     = alarm_cond;
  assign alarm_evt.rd_clear = reg_rd && (reg_addr == cfa_pkg::ADDR_ALARM_LATCH);
  assign alarm_evt.soft_rst = soft_reset;

  cfa_flag_bank #(.W(8)) u_fault_bank (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .evt      (fault_evt.bank)
  );

  cfa_flag_bank #(.W(8)) u_alarm_bank (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .evt      (alarm_evt.bank)
  );

  // ------------------------------------------------------------------
  // mask registers
  // ------------------------------------------------------------------
  // R2: alarm mask read-write
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      alarm_mask_reg <= cfa_pkg::MASK_RESET;
    end else if (soft_reset) begin
      alarm_mask_reg <= cfa_pkg::MASK_RESET;
    end else if (reg_wr && reg_addr == cfa_pkg::ADDR_ALARM_MASK) begin
      alarm_mask_reg <= reg_wdata;
    end
  end

  // R14: fault mask register
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      fault_mask_reg <= cfa_pkg::MASK_RESET;
    end else if (soft_reset) begin
      fault_mask_reg <= cfa_pkg::MASK_RESET;
    end else if (reg_wr && reg_addr == cfa_pkg::ADDR_FAULT_MASK) begin
      fault_mask_reg <= reg_wdata;
    end
  end

  // ------------------------------------------------------------------
  // read data
  // ------------------------------------------------------------------
  always_comb begin
    unique case (reg_addr)
      cfa_pkg::ADDR_ALARM_LATCH: rdata_next = alarm_evt.flags;
      cfa_pkg::ADDR_ALARM_MASK:  rdata_next = alarm_mask_reg;
      cfa_pkg::ADDR_FAULT_LIVE:  rdata_next = fault_live_reg;
      cfa_pkg::ADDR_FAULT_LATCH: rdata_next = fault_evt.flags;
      cfa_pkg::ADDR_FAULT_MASK:  rdata_next = fault_mask_reg;
      default:                   rdata_next = 8'h00;
    endcase
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= rdata_next;
    end
  end

  // ------------------------------------------------------------------
  // interrupt
  // ------------------------------------------------------------------
  // R1: alarm mask gating
  // R15: low while pending
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      int_n <= 1'b1;
    end else begin
      int_n <= ~(|(alarm_evt.flags & ~alarm_mask_reg) |
                 |(fault_evt.flags & ~fault_mask_reg));
    end
  end

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  sequence s_write_alarm_mask;
    reg_wr && !soft_reset && reg_addr == cfa_pkg::ADDR_ALARM_MASK;
  endsequence

  AST_MASK_WRITE: assert property (@(posedge core_clk) disable iff (!reset_n) // R2
    s_write_alarm_mask |=> (alarm_mask_reg == $past(reg_wdata)))
    else $error("alarm mask write not stored");

  AST_SOFT_RESET: assert property (@(posedge core_clk) disable iff (!reset_n) // R2
    soft_reset |=> (alarm_mask_reg == 8'h00 && fault_mask_reg == 8'h00))
    else $error("soft reset left mask bits set");

  AST_MASKED_QUIET: assert property (@(posedge core_clk) disable iff (!reset_n) // R1
    ((alarm_evt.flags & ~alarm_mask_reg) == 8'h00 &&
     (fault_evt.flags & ~fault_mask_reg) == 8'h00) |=> int_n)
    else $error("interrupt asserted with all pending events masked");

  AST_INT_PENDING: assert property (@(posedge core_clk) disable iff (!reset_n) // R15
    ((alarm_evt.flags & ~alarm_mask_reg) != 8'h00) |=> !int_n)
    else $error("unmasked alarm flag did not pull interrupt");

  AST_FAULT_INT: assert property (@(posedge core_clk) disable iff (!reset_n) // R14
    ((fault_evt.flags & ~fault_mask_reg) != 8'h00) |=> !int_n)
    else $error("unmasked fault flag did not pull interrupt");

  AST_LIVE_FOLLOWS: assert property (@(posedge core_clk) disable iff (!reset_n) // R4
    ##1 fault_live_reg[cfa_pkg::BIT_BAT_OV] == $past(battery_overvoltage))
    else $error("live fault state does not follow condition");

  AST_BAT_HOT: assert property (@(posedge core_clk) disable iff (!reset_n) // R7
    (battery_temp_sense < battery_temp_fault_level) |=> fault_live_reg[cfa_pkg::BIT_BAT_OT])
    else $error("battery over-temperature not reported");

  AST_CONN_HOT: assert property (@(posedge core_clk) disable iff (!reset_n) // R8
    (connector_temp_sense < connector_temp_fault_level) |=> fault_live_reg[cfa_pkg::BIT_CONN_OT])
    else $error("connector over-temperature not reported");

  AST_DIE_HOT: assert property (@(posedge core_clk) disable iff (!reset_n) // R9
    (die_temp > die_temp_alarm_level) |=> fault_live_reg[cfa_pkg::BIT_DIE_OT])
    else $error("die alarm not reported");

  AST_NEAR_FLAG: assert property (@(posedge core_clk) disable iff (!reset_n) // R12
    (fault_live_reg[cfa_pkg::BIT_NEAR_LIMIT] && !soft_reset)
      |=> fault_evt.flags[cfa_pkg::BIT_NEAR_LIMIT])
    else $error("near-limit flag not latched");

  AST_ALARM_FLAG: assert property (@(posedge core_clk) disable iff (!reset_n) // R13
    (alarm_cond[cfa_pkg::BIT_BAT_OV_ALM] && !soft_reset)
      |=> alarm_evt.flags[cfa_pkg::BIT_BAT_OV_ALM])
    else $error("alarm flag not latched");

endmodule // cfa_fault_alarm_regs

// ### verif/cfa_host_model.sv
// Purpose: host on the register port, issues single byte writes and reads
// Assumes: strobes change at the falling edge, one idle cycle between requests
// Notes:   write data is inverted after release so stale values never look valid
`timescale 1ns/1ps
module cfa_host_model (
  // clock
  input  wire logic       core_clk,
  // register port
  output logic      [7:0] reg_addr,
  output logic            reg_wr,
  output logic            reg_rd,
  output logic      [7:0] reg_wdata,
  input  wire logic [7:0] reg_rdata
);
  initial begin
    reg_addr  = 8'h00;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_wdata = 8'h00;
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge core_clk);
    reg_addr  = a;
    reg_wdata = v;
    reg_wr    = 1'b1;
    @(negedge core_clk);
    reg_wr    = 1'b0;
    reg_wdata = ~v;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(negedge core_clk);
    reg_addr = a;
    reg_rd   = 1'b1;
    @(negedge core_clk);
    reg_rd   = 1'b0;
    v        = reg_rdata;
  endtask
endmodule // cfa_host_model

// ### verif/cfa_fault_alarm_regs_tb.sv
// Purpose: self-checking bench for the alarm and fault event registers
// Assumes: inputs change at the falling edge of core_clk
// Notes:   waits use the fixed path latencies of the block
`timescale 1ns/1ps
module cfa_fault_alarm_regs_tb;
  logic        core_clk;
  logic        reset_n;
  logic [7:0]  reg_addr;
  logic        reg_wr;
  logic        reg_rd;
  logic [7:0]  reg_wdata;
  logic [7:0]  reg_rdata;
  logic        soft_reset;
  logic [7:0]  alarm_cond;
  logic        battery_overvoltage;
  logic        battery_overcurrent;
  logic        input_overvoltage;
  logic        input_overcurrent;
  logic [11:0] battery_temp_sense;
  logic [11:0] connector_temp_sense;
  logic [11:0] die_temp;
  logic        int_n;
  logic [7:0]  d;
  int          bad_count;
  int          checked;
  // fault cases: four power faults, then temperature readings against level 1000
  logic [3:0]  pw [10] = '{4'h8, 4'h4, 4'h2, 4'h1, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0};
  logic [11:0] bts [10] = '{12'h7D0, 12'h7D0, 12'h7D0, 12'h7D0, 12'h3E7, 12'h3B5, 12'h7D0,
                            12'h7D0, 12'h7D0, 12'h7D0};
  logic [11:0] cts [10] = '{12'h7D0, 12'h7D0, 12'h7D0, 12'h7D0, 12'h7D0, 12'h7D0, 12'h41A,
                            12'h41B, 12'h384, 12'h7D0};
  logic [11:0] dt [10]  = '{12'h3E8, 12'h3E8, 12'h3E8, 12'h3E8, 12'h3E8, 12'h3E8, 12'h3E8,
                            12'h3E8, 12'h3E8, 12'h3E9};
  logic [7:0]  ex [10] = '{8'h80, 8'h40, 8'h20, 8'h10, 8'h0C, 8'h04, 8'h08, 8'h00, 8'h02, 8'h01};

  cfa_host_model host (.core_clk(core_clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

  cfa_fault_alarm_regs #(.TW(12)) dut (.core_clk(core_clk), .reset_n(reset_n),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .soft_reset(soft_reset), .alarm_cond(alarm_cond),
    .battery_overvoltage(battery_overvoltage), .battery_overcurrent(battery_overcurrent),
    .input_overvoltage(input_overvoltage), .input_overcurrent(input_overcurrent),
    .battery_temp_sense(battery_temp_sense), .battery_temp_fault_level(12'h3E8),
    .connector_temp_sense(connector_temp_sense), .connector_temp_fault_level(12'h3E8),
    .die_temp(die_temp), .die_temp_alarm_level(12'h3E8), .int_n(int_n));

  // --------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic idle();
    {battery_overvoltage, battery_overcurrent, input_overvoltage, input_overcurrent} = 4'h0;
    battery_temp_sense   = 12'h7D0;
    connector_temp_sense = 12'h7D0;
    die_temp             = 12'h3E8;
  endtask

  task automatic report_and_stop();
    $display("mismatches %0d, comparisons %0d", bad_count, checked);
    if (bad_count == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // --------------------------------------------------------------
  // clock, watchdog, sequence
  // --------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  initial begin
    #2000000;
    bad_count++;
    report_and_stop();
  end

  initial begin
    bad_count  = 0;
    checked    = 0;
    reset_n    = 1'b0;
    soft_reset = 1'b0;
    alarm_cond = 8'h00;
    idle();
    repeat (4) @(negedge core_clk);
    reset_n = 1'b1;
    @(negedge core_clk);
    check({7'h00, int_n}, 8'h01);
    host.rd(8'h0F, d); check(d, 8'h00);
    host.wr(8'h0F, 8'hA5);
    host.rd(8'h0F, d); check(d, 8'hA5);
    @(negedge core_clk) soft_reset = 1'b1;
    @(negedge core_clk) soft_reset = 1'b0;
    host.rd(8'h0F, d); check(d, 8'h00);
    host.wr(8'h11, 8'hFF);
    host.rd(8'h11, d); check(d, 8'h00);
    host.wr(8'h10, 8'hFF);
    host.rd(8'h10, d); check(d, 8'h00);
    host.rd(8'h20, d); check(d, 8'h00);
    for (int i = 0; i < 8; i++) begin
      for (int m = 0; m < 2; m++) begin
        host.wr(8'h0F, (m == 1) ? (8'h01 << i) : 8'h00);
        @(negedge core_clk) alarm_cond = 8'h01 << i;
        @(negedge core_clk) alarm_cond = 8'h00;
        repeat (3) @(negedge core_clk);
        check({7'h00, int_n}, {7'h00, m == 1});
        host.rd(8'h0E, d); check(d, 8'h01 << i);
        repeat (2) @(negedge core_clk);
        check({7'h00, int_n}, 8'h01);
      end
    end
    host.wr(8'h0F, 8'h00);
    for (int k = 0; k < 10; k++) begin
      @(negedge core_clk);
      {battery_overvoltage, battery_overcurrent, input_overvoltage, input_overcurrent} = pw[k];
      battery_temp_sense   = bts[k];
      connector_temp_sense = cts[k];
      die_temp             = dt[k];
      repeat (4) @(negedge core_clk);
      host.rd(8'h10, d); check(d, ex[k]);
      check({7'h00, int_n}, {7'h00, ex[k] == 8'h00});
      idle();
      repeat (4) @(negedge core_clk);
      host.rd(8'h10, d); check(d, 8'h00);
      host.rd(8'h11, d); check(d, ex[k]);
      host.rd(8'h11, d); check(d, 8'h00);
      repeat (2) @(negedge core_clk);
      check({7'h00, int_n}, 8'h01);
    end
    host.wr(8'h12, 8'hFF);
    host.rd(8'h12, d); check(d, 8'hFF);
    @(negedge core_clk) battery_overvoltage = 1'b1;
    repeat (5) @(negedge core_clk);
    check({7'h00, int_n}, 8'h01);
    // unmasking a pending flag pulls the interrupt
    host.wr(8'h12, 8'h7F);
    repeat (2) @(negedge core_clk);
    check({7'h00, int_n}, 8'h00);
    idle();
    repeat (4) @(negedge core_clk);
    host.rd(8'h11, d); check(d, 8'h80);
    host.wr(8'h12, 8'h00);
    // soft reset clears latched flags and the fault mask
    host.wr(8'h12, 8'h3C);
    @(negedge core_clk) alarm_cond = 8'h01;
    @(negedge core_clk) alarm_cond = 8'h00;
    @(negedge core_clk) soft_reset = 1'b1;
    @(negedge core_clk) soft_reset = 1'b0;
    host.rd(8'h0E, d); check(d, 8'h00);
    host.rd(8'h12, d); check(d, 8'h00);
    check({7'h00, int_n}, 8'h01);
    report_and_stop();
  end
endmodule // cfa_fault_alarm_regs_tb
